/* design/gmc_general_mask.sv */
// Contract
// R01: With the pin gate cleared the interrupt pin stays inactive whatever the mask register holds.
// R02: With the pin gate set any unmasked interrupt bit can drive the interrupt pin active.
// R03: The pin gate affects only the interrupt pin, never how event flags are set or cleared.
// R04: With wide access set the device answers only at address bit zero low, with 16-bit data for all eight channels.
// R05: With wide access cleared the device acts as two four-channel targets with 8-bit data at two consecutive addresses.
// R06: With multi-level priority set, fast shutdown uses the 3-bit priority scheme.
// R07: With multi-level priority cleared, fast shutdown uses one priority bit per channel.
// R08: With class change-only set, a class event is raised only when the class result differs from the previous one.
// R09: With class change-only cleared, a class event is raised after every classification cycle.
// R10: With detect change-only set, a detection event is raised only when the detection result differs from the previous one.
// R11: With detect change-only cleared, a detection event is raised after every detection cycle.
// R12: The host keeps the fast shutdown input idle low for 200 us before raising multi-level priority.
// R13: The host sets wide access only in the channel 1-4 register instance to enable 16-bit operation.
// R14: Unused bits 6, 1 and 0 are plain read/write storage that resets to zero and does nothing.
`timescale 1ns/100ps
`default_nettype none
`include "gmc_map.svh"
module gmc_general_mask #(
	parameter int CH = 8,
	parameter int RW = 4
) (
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// Register access from the serial target front end
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [7:0]        reg_cmd_i,
	input  wire logic              reg_a0_i,
	input  wire logic [15:0]       reg_wdata_i,
	output var  logic [15:0]       reg_rdata_o,
	output var  logic              reg_ack_o,
	// Interrupt gating
	input  wire logic [15:0]       int_pending_i,
	input  wire logic [15:0]       int_mask_i,
	output var  logic              irq_n_o,
	// Fast shutdown
	input  wire logic              fast_shutdown_input_i,
	input  wire logic [2:0]        shutdown_level_i,
	input  wire logic [CH-1:0]     prio_1bit_i,
	input  wire logic [CH*3-1:0]   prio_3bit_i,
	output var  logic [CH-1:0]     shutdown_o,
	// Discovery events
	input  wire logic [CH-1:0]     det_done_i,
	input  wire logic [CH*RW-1:0]  det_result_i,
	input  wire logic [CH-1:0]     cls_done_i,
	input  wire logic [CH*RW-1:0]  cls_result_i,
	output var  logic [CH-1:0]     detection_event_flag_o,
	output var  logic [CH-1:0]     class_event_flag_o,
	// Mode outputs to the rest of the controller
	output var  logic              wide_mode_o,
	output var  logic              multi_prio_o
);
	localparam int NGRP = CH / `GMC_GRP_CH;

	// The command map only has room for two groups of four channels
	if (CH != 2 * `GMC_GRP_CH) begin : g_chk_ch
		$error("gmc_general_mask serves exactly eight channels");
	end
	if (RW < 1) begin : g_chk_rw
		$error("gmc_general_mask needs a result of at least one bit");
	end

	// Channel to configuration group; channels 1-4 form group 0
	function automatic int grp_of(input int ch);
		grp_of = ch / `GMC_GRP_CH;
	endfunction : grp_of

	function automatic logic grp_irq(input gmc_pkg::gmc_byte_t cfg,
			input logic [7:0] pend, input logic [7:0] msk);
		// Gate only the pin; pending and event state are untouched
		grp_irq = cfg[`GMC_BIT_IRQ_GATE] & |(pend & msk); // [R01] [R02] [R03]
	endfunction : grp_irq

	gmc_pkg::gmc_byte_t cfg_reg [NGRP];
	gmc_pkg::gmc_byte_t cfg_next [NGRP];
	logic [15:0]        rdata_reg;
	logic [15:0]        rdata_next;
	logic               ack_reg;
	logic               ack_next;
	logic               irq_n_reg;
	logic               irq_n_next;
	logic [CH-1:0]      shut_reg;
	logic [CH-1:0]      shut_next;
	gmc_pkg::gmc_acc_t  acc_mode;
	logic               hit;
	logic               acc_req;
	// Per-channel copies of the group settings
	logic [CH-1:0]      multi_ch;
	logic [CH-1:0]      det_chg_ch;
	logic [CH-1:0]      cls_chg_ch;

	// Bus width and addressing follow the channel 1-4 instance only
	assign acc_mode = gmc_pkg::gmc_acc_t'(cfg_reg[0][`GMC_BIT_WIDE_ACC]); // [R13]
	// Wide mode answers at A0 low only; narrow mode answers at both addresses
	assign hit = (reg_cmd_i == `GMC_CMD_GEN_MASK) &&
		((acc_mode == gmc_pkg::GMC_ACC_NARROW) || !reg_a0_i); // [R04] [R05]
	// A refused access raises no ack and leaves read data and the configuration untouched
	assign acc_req = hit && (reg_wr_i || reg_rd_i);

	always_comb begin
		for (int g = 0; g < NGRP; g++) begin
			cfg_next[g] = cfg_reg[g];
		end
		// Read data holds until the next accepted access, so it may be fetched late
		rdata_next = rdata_reg;
		ack_next   = 1'b0;
		if (acc_req) begin
			ack_next = 1'b1;
			if (acc_mode == gmc_pkg::GMC_ACC_WIDE) begin
				// Low byte is channels 1-4, high byte channels 5-8; a write that
				// clears wide mode still lands whole and the next access is narrow
				if (reg_wr_i) begin
					cfg_next[0] = reg_wdata_i[7:0]; // [R04] [R14]
					cfg_next[1] = reg_wdata_i[15:8];
				end
				rdata_next = {cfg_reg[1], cfg_reg[0]}; // [R04]
			end else begin
				if (reg_wr_i) begin
					cfg_next[reg_a0_i] = reg_wdata_i[7:0]; // [R05] [R14]
				end
				rdata_next = {8'h00, cfg_reg[reg_a0_i]}; // [R05]
			end
		end
	end

	// Registered so the pin cannot glitch while pending bits settle
	always_comb begin
		irq_n_next = 1'b1;
		for (int g = 0; g < NGRP; g++) begin
			if (grp_irq(cfg_reg[g], int_pending_i[g*8 +: 8], int_mask_i[g*8 +: 8])) begin
				irq_n_next = 1'b0;
			end
		end
	end

	for (genvar c = 0; c < CH; c++) begin : g_chan
		assign multi_ch[c]   = cfg_reg[grp_of(c)][`GMC_BIT_MULTI_PRIO]; // [R06] [R07]
		assign det_chg_ch[c] = cfg_reg[grp_of(c)][`GMC_BIT_DET_CHG]; // [R10] [R11]
		assign cls_chg_ch[c] = cfg_reg[grp_of(c)][`GMC_BIT_CLS_CHG]; // [R08] [R09]
	end

	// The 3-bit code is sampled as a level; stream recovery lives upstream and
	// relies on the idle time before the mode is raised [R12]
	always_comb begin
		shut_next = '0;
		for (int c = 0; c < CH; c++) begin
			if (multi_ch[c]) begin
				shut_next[c] = (shutdown_level_i != 3'h0) &&
					(prio_3bit_i[c*3 +: 3] >= shutdown_level_i); // [R06]
			end else begin
				shut_next[c] = fast_shutdown_input_i && prio_1bit_i[c]; // [R07]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int g = 0; g < NGRP; g++) begin
				cfg_reg[g] <= `GMC_CFG_RESET; // [R14]
			end
			rdata_reg <= 16'h0000;
			ack_reg   <= 1'b0;
		end else begin
			for (int g = 0; g < NGRP; g++) begin
				cfg_reg[g] <= cfg_next[g];
			end
			rdata_reg <= rdata_next;
			ack_reg   <= ack_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= irq_n_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			shut_reg <= '0;
		end else begin
			shut_reg <= shut_next;
		end
	end

	// Results are stored on every completed cycle whatever the mode, so a later
	// switch to change-only compares against the latest result
	gmc_evt_if #(.CH(CH), .RW(RW)) det_if ();
	gmc_evt_if #(.CH(CH), .RW(RW)) cls_if ();

	assign det_if.change_only = det_chg_ch; // [R10] [R11]
	assign cls_if.change_only = cls_chg_ch; // [R08] [R09]
	assign det_if.done   = det_done_i;
	assign det_if.result = det_result_i;
	assign cls_if.done   = cls_done_i;
	assign cls_if.result = cls_result_i;

	gmc_evt_filter #(.CH(CH), .RW(RW)) u_det (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.evt       (det_if.filt)
	);

	gmc_evt_filter #(.CH(CH), .RW(RW)) u_cls (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.evt       (cls_if.filt)
	);

	assign reg_rdata_o            = rdata_reg;
	assign reg_ack_o              = ack_reg;
	assign irq_n_o                = irq_n_reg;
	assign shutdown_o             = shut_reg;
	assign detection_event_flag_o = det_if.set;
	assign class_event_flag_o     = cls_if.set;
	assign wide_mode_o            = cfg_reg[0][`GMC_BIT_WIDE_ACC];
	assign multi_prio_o           = cfg_reg[0][`GMC_BIT_MULTI_PRIO];
endmodule : gmc_general_mask
`default_nettype wire

/* design/gmc_map.svh */
`ifndef GMC_MAP_SVH
`define GMC_MAP_SVH

// Command code of the general mask/configuration register
`define GMC_CMD_GEN_MASK     8'h17
// Field positions
`define GMC_BIT_IRQ_GATE     3'd7
`define GMC_BIT_WIDE_ACC     3'd5
`define GMC_BIT_MULTI_PRIO   3'd4
`define GMC_BIT_CLS_CHG      3'd3
`define GMC_BIT_DET_CHG      3'd2
// Value after reset: only the interrupt pin gate is set
`define GMC_CFG_RESET        8'h80
// Channels served by one register instance
`define GMC_GRP_CH           4

`endif

/* design/gmc_pkg.sv */
package gmc_pkg;
	typedef logic [7:0] gmc_byte_t;
	typedef enum logic {
		GMC_ACC_NARROW = 1'b0,
		GMC_ACC_WIDE   = 1'b1
	} gmc_acc_t;
	typedef logic [2:0] gmc_prio_t;
endpackage : gmc_pkg

/* design/gmc_evt_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface gmc_evt_if #(
	parameter int CH = 8,
	parameter int RW = 4
);
	logic [CH-1:0]    done;
	logic [CH*RW-1:0] result;
	logic [CH-1:0]    change_only;
	logic [CH-1:0]    set;

	modport filt (input done, input result, input change_only, output set);
	modport ctrl (output done, output result, output change_only, input set);
endinterface : gmc_evt_if
`default_nettype wire

/* design/gmc_evt_filter.sv */
`timescale 1ns/100ps
`default_nettype none
// Per-channel event qualifier: every completed cycle, or only a changed result
module gmc_evt_filter #(
	parameter int CH = 8,
	parameter int RW = 4
) (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	gmc_evt_if.filt   evt
);
	logic [CH*RW-1:0] prev_reg;
	logic [CH*RW-1:0] prev_next;
	logic [CH-1:0]    seen_reg;
	logic [CH-1:0]    seen_next;
	logic [CH-1:0]    set_reg;
	logic [CH-1:0]    set_next;

	always_comb begin
		prev_next = prev_reg;
		seen_next = seen_reg;
		set_next  = '0;
		for (int c = 0; c < CH; c++) begin
			if (evt.done[c]) begin
				// First result after reset has nothing to compare with, so it counts as a change
				if (!evt.change_only[c]) begin
					set_next[c] = 1'b1; // [R09] [R11]
				end else begin
					set_next[c] = !seen_reg[c] ||
						(evt.result[c*RW +: RW] != prev_reg[c*RW +: RW]); // [R08] [R10]
				end
				prev_next[c*RW +: RW] = evt.result[c*RW +: RW];
				seen_next[c]          = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prev_reg <= '0;
			seen_reg <= '0;
			set_reg  <= '0;
		end else begin
			prev_reg <= prev_next;
			seen_reg <= seen_next;
			set_reg  <= set_next;
		end
	end

	assign evt.set = set_reg;
endmodule : gmc_evt_filter
`default_nettype wire

/* sim/gmc_general_mask_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module gmc_general_mask_assertions (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_cmd_i,
	input wire logic        reg_a0_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        reg_ack_o,
	input wire logic [15:0] int_pending_i,
	input wire logic [15:0] int_mask_i,
	input wire logic        irq_n_o,
	input wire logic [7:0]  det_done_i,
	input wire logic [7:0]  detection_event_flag_o,
	input wire logic        wide_mode_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic acc;
	assign acc = (reg_wr_i | reg_rd_i) && reg_cmd_i == 8'h17;
	AST_ACK_CAUSE: assert property (reg_ack_o |-> $past(acc))
		else $error("ack without access");
	AST_A0_ZERO: assert property (acc && !reg_a0_i |=> reg_ack_o)
		else $error("access at a0 low not acked");
	AST_WIDE_A0: assert property (acc && wide_mode_o && reg_a0_i |=> !reg_ack_o)
		else $error("wide access at a0 high acked");
	AST_NARROW_A1: assert property (acc && !wide_mode_o |=> reg_ack_o)
		else $error("narrow access not acked");
	AST_NARROW_HI: assert property (acc && !reg_wr_i && !wide_mode_o |=> reg_rdata_o[15:8] == 8'h00)
		else $error("narrow read high byte set");
	AST_RDATA_HOLD: assert property (!reg_ack_o |-> $stable(reg_rdata_o))
		else $error("read data moved without ack");
	AST_IRQ_QUIET: assert property ((int_pending_i & int_mask_i) == 16'h0000 |=> irq_n_o)
		else $error("irq active with nothing pending");
	AST_DET_CAUSE: assert property ((detection_event_flag_o & ~$past(det_done_i)) == 8'h00)
		else $error("detect flag without done");
	cover property (acc && wide_mode_o ##1 reg_ack_o);
	cover property (!irq_n_o);
	cover property (detection_event_flag_o != 8'h00);
endmodule : gmc_general_mask_assertions
bind gmc_general_mask gmc_general_mask_assertions gmc_general_mask_assertions_i (.clk_i,
	.sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_cmd_i, .reg_a0_i, .reg_rdata_o, .reg_ack_o,
	.int_pending_i, .int_mask_i, .irq_n_o, .det_done_i, .detection_event_flag_o, .wide_mode_o);
`default_nettype wire

/* sim/gmc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module gmc_host_model (
	input  wire logic        clk_i,
	output var  logic        wr_o,
	output var  logic        rd_o,
	output var  logic [7:0]  cmd_o,
	output var  logic        a0_o,
	output var  logic [15:0] wdata_o,
	output var  logic        fsd_o
);
	initial begin
		{wr_o, rd_o, a0_o, fsd_o, cmd_o, wdata_o} = 28'h0000000;
	end
	// One strobe cycle is one access, so the request is never held past its edge
	task automatic acc(input logic w, input logic a, input logic [7:0] c, input logic [15:0] d);
		logic [15:0] v;
		v = a ? (d & 16'hFFDF) : d;
		if (w && v[4]) begin
			fsd_o = 1'b0; // Keeps the priority stream in step
			repeat (8000) @(negedge clk_i);
		end
		@(negedge clk_i);
		{wr_o, rd_o, a0_o, cmd_o, wdata_o} = {w, !w, a, c, v};
		@(negedge clk_i);
		{wr_o, rd_o, cmd_o, wdata_o} = {2'b00, ~c, ~v};
	endtask : acc
endmodule : gmc_host_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [15:0] pend = 16'h0000, msk = 16'h0000, rdata, wdata;
	logic [7:0]  p1 = 8'h00, ddone = 8'h00, cdone = 8'h00, shut, dflag, cflag, cmd, ex;
	logic [2:0]  lvl = 3'h0;
	logic [23:0] p3 = 24'h000000;
	logic [31:0] dres = 32'h00000000, cres = 32'h00000000;
	logic        wr, rd, a0, fsd, ack, irq_n, wide, mprio;
	logic [16:0] expq[$], e;
	int          mismatches = 0, checks_done = 0;
	always #12.5 clk_i = ~clk_i;
	gmc_host_model host_i (.clk_i, .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .a0_o(a0),
		.wdata_o(wdata), .fsd_o(fsd));
	gmc_general_mask gmc_general_mask_i (.clk_i, .sys_rst_i, .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_cmd_i(cmd), .reg_a0_i(a0), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_ack_o(ack), .int_pending_i(pend), .int_mask_i(msk), .irq_n_o(irq_n),
		.fast_shutdown_input_i(fsd), .shutdown_level_i(lvl), .prio_1bit_i(p1), .prio_3bit_i(p3),
		.shutdown_o(shut), .det_done_i(ddone), .det_result_i(dres), .cls_done_i(cdone),
		.cls_result_i(cres), .detection_event_flag_o(dflag), .class_event_flag_o(cflag),
		.wide_mode_o(wide), .multi_prio_o(mprio));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rd_exp(input logic a, input logic [15:0] v);
		expq.push_back({1'b1, v});
		host_i.acc(1'b0, a, 8'h17, 16'h0000);
	endtask : rd_exp
	task automatic wr_cfg(input logic a, input logic [15:0] v);
		expq.push_back(17'h00000);
		host_i.acc(1'b1, a, 8'h17, v);
	endtask : wr_cfg
	task automatic irq_t(input logic [15:0] p, input logic [15:0] m, input logic v);
		{pend, msk} = {p, m};
		repeat (2) @(negedge clk_i);
		check("irq_n", {15'h0000, irq_n}, {15'h0000, v});
	endtask : irq_t
	task automatic ev(input logic [7:0] v);
		{ddone, cdone} = 16'hFFFF;
		@(negedge clk_i);
		{ddone, cdone} = 16'h0000;
		check("det flag", {8'h00, dflag}, {8'h00, v});
		check("cls flag", {8'h00, cflag}, {8'h00, v});
		@(negedge clk_i);
	endtask : ev
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// An unexpected ack finds no note and is compared against an impossible value
	always @(negedge clk_i) begin
		if (ack === 1'b1) begin
			e = (expq.size() != 0) ? expq.pop_front() : 17'h1FFFF;
			if (e[16]) check("rdata", rdata, e[15:0]);
		end
	end
	initial begin
		repeat (40000) @(negedge clk_i);
		mismatches++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hE1A3C33C));
		repeat (4) @(negedge clk_i);
		sys_rst_i = 1'b0;
		rd_exp(1'b0, 16'h0080);
		rd_exp(1'b1, 16'h0080);
		wr_cfg(1'b0, 16'h00C3);
		wr_cfg(1'b1, 16'h0043);
		host_i.acc(1'b1, 1'b0, 8'h16, 16'h00FF);
		rd_exp(1'b0, 16'h00C3);
		rd_exp(1'b1, 16'h0043);
		$display("test registers done");
		irq_t(16'h0100, 16'h0100, 1'b1);
		irq_t(16'h0001, 16'h0001, 1'b0);
		irq_t(16'h0001, 16'h0000, 1'b1);
		$display("test interrupt done");
		p1 = 8'($urandom);
		p3 = 24'($urandom);
		host_i.fsd_o = 1'b1;
		repeat (2) @(negedge clk_i);
		check("shut 1-bit", {8'h00, shut}, {8'h00, p1});
		check("wide", {15'h0000, wide}, 16'h0000);
		check("multi prio", {15'h0000, mprio}, 16'h0000);
		wr_cfg(1'b0, 16'h0030);
		wr_cfg(1'b0, 16'h1030);
		lvl = 3'h3;
		for (int c = 0; c < 8; c++) ex[c] = p3[3*c +: 3] >= 3'h3;
		repeat (2) @(negedge clk_i);
		check("shut 3-bit", {8'h00, shut}, {8'h00, ex});
		check("wide", {15'h0000, wide}, 16'h0001);
		check("multi prio", {15'h0000, mprio}, 16'h0001);
		rd_exp(1'b0, 16'h1030);
		host_i.acc(1'b0, 1'b1, 8'h17, 16'h0000);
		$display("test priority and wide done");
		dres = $urandom;
		cres = $urandom;
		wr_cfg(1'b0, 16'h0C2C);
		ev(8'hFF);
		ev(8'h00);
		{dres, cres} = ~{dres, cres};
		ev(8'hFF);
		wr_cfg(1'b0, 16'h0020);
		ev(8'hFF);
		ev(8'hFF);
		repeat (2) @(negedge clk_i);
		check("notes left", 16'(expq.size()), 16'h0000);
		$display("test events done");
		print_verdict();
	end
endmodule : tb
`default_nettype wire
